// ===== inc/rtk_defs.svh
`ifndef RTK_DEFS_SVH
`define RTK_DEFS_SVH

// Register byte offsets on the local port
`define RTK_ADDR_W          4
`define RTK_OFS_MODE        4'h0
`define RTK_OFS_ALARM       4'h4
`define RTK_OFS_VALUE       4'h8
`define RTK_OFS_STATUS      4'hC

// Mode register field positions
`define RTK_MODE_DIV_LSB    0
`define RTK_MODE_DIV_MSB    15
`define RTK_MODE_ALM_IEN    16
`define RTK_MODE_TICK_IEN   17
`define RTK_MODE_RESTART    18
`define RTK_MODE_DISABLE    20
`define RTK_MODE_SEC_SEL    24

// Status register field positions
`define RTK_STAT_ALARM      0
`define RTK_STAT_TICK       1

// Reset values
`define RTK_DIV_RESET       16'h8000
`define RTK_ALARM_RESET     32'h0FFF_FFFF
`define RTK_COUNT_RESET     32'h0000_0000

// Slow clock periods from status read to interrupt release
`define RTK_IRQ_HOLD_SLOW   2

`endif

// ===== inc/rtk_pkg.sv
package rtk_pkg;

   // Register port request from software
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } rtk_bus_req_t;

   // Live configuration as seen by the slow-rate logic
   typedef struct packed {
      logic        second_tick_select;
      logic        timer_disable;
      logic        tick_irq_enable;
      logic        alarm_irq_enable;
      logic [15:0] prescale_divisor;
   } rtk_mode_t;

   // Sticky event flags
   typedef struct packed {
      logic prescale_tick_flag;
      logic alarm_match_flag;
   } rtk_status_t;

   // Interrupt hold-off after a status read
   typedef enum logic [1:0] {
      RTK_IRQ_LIVE,
      RTK_IRQ_HOLD_A,
      RTK_IRQ_HOLD_B
   } rtk_irq_state_t;

endpackage : rtk_pkg

// ===== logic/rtk_counter.sv
`timescale 1ns/10ps
`include "rtk_defs.svh"

module rtk_counter
   import rtk_pkg::*;
#(
   parameter int CNT_W = 32
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Control
   input  wire logic             clear,
   input  wire logic             inc,
   // Count
   output logic [CNT_W-1:0]      value,
   output logic [CNT_W-1:0]      next_value
);

   // Natural wrap to zero after all ones
   assign next_value = value + {{(CNT_W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         value <= `RTK_COUNT_RESET;
      else if (clear)
         value <= '0;
      else if (inc)
         value <= next_value;
   end

endmodule : rtk_counter

// ===== logic/rtk_prescaler.sv
`timescale 1ns/10ps
`include "rtk_defs.svh"

module rtk_prescaler
   import rtk_pkg::*;
#(
   parameter int DIV_W = 16
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Control
   input  wire logic             step,
   input  wire logic             reload,
   input  wire logic [DIV_W-1:0] divisor,
   // Event
   output logic                  rollover
);

   logic [DIV_W:0] remain;

   // Divisor zero means the full 2^DIV_W period
   function automatic logic [DIV_W:0] period_of(input logic [DIV_W-1:0] d);
      if (d == '0)
         period_of = {1'b1, {DIV_W{1'b0}}};
      else
         period_of = {1'b0, d};
   endfunction : period_of

   // Down counter; reload restarts a full period
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         remain <= {1'b0, `RTK_DIV_RESET};
      else if (reload)
         remain <= period_of(divisor);
      else if (step)
      begin
         if (remain <= {{DIV_W{1'b0}}, 1'b1})
            remain <= period_of(divisor);
         else
            remain <= remain - {{DIV_W{1'b0}}, 1'b1};
      end
   end

   // One pulse per period, in the cycle after the slow step that ends it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rollover <= 1'b0;
      else
         rollover <= step && !reload && (remain <= {{DIV_W{1'b0}}, 1'b1});
   end

endmodule : rtk_prescaler

// ===== logic/rtk_timer.sv
`timescale 1ns/10ps
`include "rtk_defs.svh"

module rtk_timer
   import rtk_pkg::*;
#(
   parameter int DIV_W = 16,
   parameter int CNT_W = 32
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // Slow clock and one-second tick, one-cycle enables
   input  wire logic              slow_clock_en,
   input  wire logic              second_tick,
   // Register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   // Event outputs
   output logic                   irq,
   output logic                   alarm
);

   // Software-facing request and configuration
   rtk_bus_req_t   req;
   rtk_mode_t      mode_sw;
   rtk_mode_t      mode_live;
   rtk_status_t    status;
   rtk_irq_state_t irq_state;
   rtk_irq_state_t next_irq_state;
   logic [31:0]    alarm_compare_value;
   // Slow-rate control, count and flags
   logic           restart_pend;
   logic           restart_live;
   logic           run_step;
   logic           rollover;
   logic           count_inc;
   logic [CNT_W-1:0] current_count_value;
   logic [CNT_W-1:0] count_next;
   logic           status_rd;
   logic           irq_raw;

   // Bundle the port into one request
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Address match, shared by the write and status-read decodes; the read mux decodes addr itself
   function automatic logic hit(input rtk_bus_req_t r, input logic [3:0] ofs);
      hit = (r.addr == ofs);
   endfunction : hit

   // Status read strobe: clears the flags and starts the hold-off
   assign status_rd = req.rd && hit(req, `RTK_OFS_STATUS);

   // Software copy of the mode register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_sw.prescale_divisor   <= `RTK_DIV_RESET;
         mode_sw.alarm_irq_enable   <= 1'b0;
         mode_sw.tick_irq_enable    <= 1'b0;
         mode_sw.timer_disable      <= 1'b0;
         mode_sw.second_tick_select <= 1'b0;
      end
      else if (req.wr && hit(req, `RTK_OFS_MODE))
      begin
         mode_sw.prescale_divisor   <= req.wdata[`RTK_MODE_DIV_MSB:`RTK_MODE_DIV_LSB];
         mode_sw.alarm_irq_enable   <= req.wdata[`RTK_MODE_ALM_IEN];
         mode_sw.tick_irq_enable    <= req.wdata[`RTK_MODE_TICK_IEN];
         mode_sw.timer_disable      <= req.wdata[`RTK_MODE_DISABLE];
         mode_sw.second_tick_select <= req.wdata[`RTK_MODE_SEC_SEL];
      end
   end

   // Restart request held until the next slow step picks it up
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         restart_pend <= 1'b0;
      else if (req.wr && hit(req, `RTK_OFS_MODE) && req.wdata[`RTK_MODE_RESTART])
         restart_pend <= 1'b1;
      else if (slow_clock_en)
         restart_pend <= 1'b0;
   end

   // Alarm compare value
   // Software keeps the alarm enable clear while this changes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         alarm_compare_value <= `RTK_ALARM_RESET;
      else if (req.wr && hit(req, `RTK_OFS_ALARM))
         alarm_compare_value <= req.wdata;
   end

   // Slow logic sees the mode only at its own steps, so a divisor
   // write never lands half way through a slow period
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_live    <= '{second_tick_select: 1'b0, timer_disable: 1'b0,
                           tick_irq_enable: 1'b0, alarm_irq_enable: 1'b0,
                           prescale_divisor: `RTK_DIV_RESET};
         restart_live <= 1'b0;
      end
      else if (slow_clock_en)
      begin
         mode_live    <= mode_sw;
         restart_live <= restart_pend;
      end
      else
         restart_live <= 1'b0;
   end

   // Disabled timer stops the prescaler steps; mode updates and a restart still land at slow steps
   assign run_step = slow_clock_en && !mode_live.timer_disable;

   // Prescaler: divisor 0 is 2^16, others count as written
   // Reload lands one cycle after the slow step that takes the new mode
   rtk_prescaler #(
      .DIV_W    (DIV_W)
   ) u_prescaler (
      .clk      (clk),
      .nrst     (nrst),
      .step     (run_step),
      .reload   (restart_live),
      .divisor  (mode_live.prescale_divisor),
      .rollover (rollover)
   );

   // Counter source: roll-overs or the one-second tick
   // A disabled timer ignores the one-second tick as well
   assign count_inc = mode_live.timer_disable ? 1'b0 :
                      mode_live.second_tick_select ? second_tick : rollover;

   rtk_counter #(
      .CNT_W      (CNT_W)
   ) u_counter (
      .clk        (clk),
      .nrst       (nrst),
      .clear      (restart_live),
      .inc        (count_inc),
      .value      (current_count_value),
      .next_value (count_next)
   );

   // Tick flag: set on any roll-over, set beats a read clear
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         status.prescale_tick_flag <= 1'b0;
      else if (rollover)
         status.prescale_tick_flag <= 1'b1;
      else if (status_rd)
         status.prescale_tick_flag <= 1'b0;
   end

   // Alarm flag: set as the counter steps onto the alarm value, so a
   // cleared flag is not raised again while the count rests there
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         status.alarm_match_flag <= 1'b0;
      else if (count_inc && !restart_live
               && (count_next[31:0] == alarm_compare_value))
         status.alarm_match_flag <= 1'b1;
      else if (status_rd)
         status.alarm_match_flag <= 1'b0;
   end

   // Wake-up output ignores the enables
   assign alarm = status.alarm_match_flag;

   // Hold-off after a status read, counted in slow steps
   always_comb
   begin
      next_irq_state = irq_state;
      case (irq_state)
         RTK_IRQ_LIVE:
            if (status_rd)
               next_irq_state = RTK_IRQ_HOLD_A;
         RTK_IRQ_HOLD_A:
            if (slow_clock_en)
               next_irq_state = RTK_IRQ_HOLD_B;
         RTK_IRQ_HOLD_B:
            if (slow_clock_en)
               next_irq_state = RTK_IRQ_LIVE;
         default:
            next_irq_state = RTK_IRQ_LIVE;
      endcase
      // A fresh read restarts the hold-off, even as an old one ends
      if (status_rd)
         next_irq_state = RTK_IRQ_HOLD_A;
   end

   // Hold-off state register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_state <= RTK_IRQ_LIVE;
      else
         irq_state <= next_irq_state;
   end

   // Interrupt line, enables taken straight from software
   // so a handler's mask acts at once, not a slow step later
   assign irq_raw = (status.alarm_match_flag && mode_sw.alarm_irq_enable)
                 || (status.prescale_tick_flag && mode_sw.tick_irq_enable);

   // Registered so the pin never glitches as flags and enables change
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= irq_raw && (next_irq_state == RTK_IRQ_LIVE);
   end

   // Read data one cycle after the strobe; write-only bits read zero
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         reg_rdata <= 32'h0000_0000;
      else if (req.rd)
      begin
         reg_rdata <= 32'h0000_0000;
         case (req.addr)
            `RTK_OFS_MODE:
            begin
               reg_rdata[`RTK_MODE_DIV_MSB:`RTK_MODE_DIV_LSB] <= mode_sw.prescale_divisor;
               reg_rdata[`RTK_MODE_ALM_IEN]  <= mode_sw.alarm_irq_enable;
               reg_rdata[`RTK_MODE_TICK_IEN] <= mode_sw.tick_irq_enable;
            end
            `RTK_OFS_ALARM:
               reg_rdata <= alarm_compare_value;
            `RTK_OFS_VALUE:
               reg_rdata <= current_count_value[31:0];
            `RTK_OFS_STATUS:
            begin
               reg_rdata[`RTK_STAT_ALARM] <= status.alarm_match_flag;
               reg_rdata[`RTK_STAT_TICK]  <= status.prescale_tick_flag;
            end
            default:
               reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : rtk_timer

// ===== verif/rtk_timer_chk.sv
`timescale 1ns/10ps
module rtk_timer_chk
   import rtk_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // Timing inputs
   input wire logic        slow_clock_en,
   input wire logic        second_tick,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Events
   input wire logic        irq,
   input wire logic        alarm
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   logic [3:0] quiet;

   // Cycles since the last slow step or second tick; saturates so it never wraps
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         quiet <= 4'hF;
      else if (slow_clock_en || second_tick)
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   end

   sequence s_stat_read;
      reg_rd && reg_addr == 4'hC;
   endsequence

   sequence s_odd_read;
      reg_rd && reg_addr[1:0] != 2'h0;
   endsequence

   a_unmapped_reads_zero: assert property (s_odd_read |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_stat_alarm_bit: assert property (s_stat_read |=> reg_rdata[0] == $past(alarm))
      else $error("status alarm bit differs from alarm output");
   a_stat_high_zero: assert property (s_stat_read |=> reg_rdata[31:2] == 30'h0)
      else $error("status upper bits not zero");
   a_irq_read_hold: assert property (s_stat_read |-> ##2 !irq)
      else $error("irq not held after status read");
   a_alarm_sticky: assert property (alarm && !reg_rd |=> alarm)
      else $error("alarm dropped without status read");
   a_alarm_cause: assert property ($rose(alarm) |-> quiet < 4'h4)
      else $error("alarm rose with no count step");
   a_irq_cause: assert property ($rose(irq) |-> quiet < 4'h5 || $past(reg_wr, 2))
      else $error("irq rose away from any slow step");
endmodule : rtk_timer_chk

bind rtk_timer rtk_timer_chk i_rtk_timer_chk (.clk(clk), .nrst(nrst),
   .slow_clock_en(slow_clock_en), .second_tick(second_tick), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq(irq), .alarm(alarm));

// ===== verif/rtk_timer_tb.sv
`timescale 1ns/10ps
module rtk_timer_tb;
   import rtk_pkg::*;

   logic        clk, nrst, slow_clock_en, second_tick, reg_wr, reg_rd, irq, alarm;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v, xs;
   int          num_errors, num_checks, m_cnt, div;

   // System clock, 8 ns period
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   rtk_timer i_rtk_timer (.clk(clk), .nrst(nrst), .slow_clock_en(slow_clock_en),
      .second_tick(second_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .alarm(alarm));

   // Seeded so that every run sees the same gaps and divisors
   function automatic logic [31:0] xorshift();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction : xorshift

   task tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data is taken in the one cycle after the strobe
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd

   // Slow steps with random gaps; gm of zero gives back-to-back steps
   task sl(input int n, input int gm);
      for (int i = 0; i < n; i++)
      begin
         if (gm > 0)
            repeat (1 + int'(xorshift() % gm)) @(posedge clk);
         slow_clock_en <= 1'b1;
         @(posedge clk);
         slow_clock_en <= (gm == 0 && i < n - 1);
      end
   endtask : sl

   task tk();
      repeat (3) @(posedge clk);
      second_tick <= 1'b1;
      @(posedge clk);
      second_tick <= 1'b0;
   endtask : tk

   // Hang guard, well past the longest sequence
   initial
   begin
      repeat (90000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      xs = 32'h0001_80FF;
      {nrst, slow_clock_en, second_tick, reg_wr, reg_rd} = 5'h0;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd(4'h0, v); chk(v, 32'h0000_8000);
      rd(4'h4, v); chk(v, 32'h0FFF_FFFF);
      rd(4'h8, v); chk(v, 32'h0);
      rd(4'h1, v);
      // Any window of 3*div steps holds exactly three roll-overs
      repeat (2)
      begin
         div = 3 + int'(xorshift() % 8);
         wr(4'h0, 32'h0004_0000 | 32'(div));
         sl(2, 4);
         m_cnt = 0;
         rd(4'h8, v); chk(v, 32'(m_cnt));
         rd(4'hC, v);
         sl(3 * div, 4);
         m_cnt += 3;
         rd(4'h8, v); chk(v, 32'(m_cnt));
         rd(4'hC, v); chk(v & 32'h2, 32'h2);
      end
      wr(4'h0, 32'h0004_0000);
      sl(2, 4);
      sl(65536, 0);
      rd(4'h8, v); chk(v, 32'h1);
      // Counter follows the second tick only
      wr(4'h0, 32'h0104_0003);
      sl(2, 4);
      rd(4'hC, v);
      sl(6, 4);
      rd(4'h8, v); chk(v, 32'h0);
      rd(4'hC, v); chk(v & 32'h2, 32'h2);
      wr(4'h4, 32'h2);
      sl(1, 4);
      tk();
      chk({31'h0, alarm}, 32'h0);
      tk();
      rd(4'h8, v); chk(v, 32'h2);
      chk({31'h0, alarm}, 32'h1);
      rd(4'hC, v); chk(v & 32'h1, 32'h1);
      chk({31'h0, alarm}, 32'h0);
      // Tick interrupt, hold-off after read, then masked
      wr(4'h0, 32'h0006_0003);
      sl(2, 4);
      rd(4'h0, v); chk(v, 32'h0002_0003);
      rd(4'hC, v);
      sl(4, 4);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rd(4'hC, v); chk(v & 32'h2, 32'h2);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // New roll-over during the hold-off, then release after the second step
      sl(1, 4);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      sl(1, 4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(4'h0, 32'h0000_0003);
      sl(4, 4);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Disabled timer must not count
      wr(4'h0, 32'h0004_0005);
      sl(2, 4);
      wr(4'h0, 32'h0010_0005);
      sl(10, 4);
      rd(4'h8, v); chk(v, 32'h0);
      tally_and_finish();
   end
endmodule : rtk_timer_tb
